// [rtl/adc_output_and_power_control.v]
// Output formatting, power-down and mode control of the sampling converter
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adc_out_regs.vh"

// Behaviour
// - Power down by itself when the sample clock period exceeds the 2 Msps limit.
// - Software power-down bit puts data, over-range and data-ready outputs into high impedance; irq and the APB outputs stay driven.
// - Delay loop is on after reset; only the control bit turns it off.
// - Each sample is a 14-bit parallel word, bit 13 most significant.
// - Over-range flag is one exactly when a pipeline word sits at a full-scale code; the 0x0000 word left by reset leaves it zero.
// - Format pins pick coding and data-ready clock latching edge, four modes.
// - Output enable low puts data, over-range and data-ready outputs high impedance.
// - Positive overdrive gives 0x3fff offset binary, 0x1fff two's complement.
// - Negative overdrive gives 0x0000 offset binary, 0x2000 two's complement.
// - Conversion starts on a falling edge; word appears 17.5 cycles later.
// - A reset pin pulse of 2 us restores mode defaults and drives data low.
module adc_output_and_power_control #(
   parameter SLOW_LIMIT_CYC = `SLOW_LIMIT_CYC,
   parameter HWRST_MIN_CYC  = `HWRST_MIN_CYC,
   parameter LATENCY        = `PIPE_LATENCY
) (
   // System clock and reset
   input  wire        clock,
   input  wire        nrst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [31:0] prdata,
   // Sample clock and analog core results (asynchronous)
   input  wire        sample_clk,
   input  wire [13:0] core_sample,
   input  wire        overdrive_pos,
   input  wire        overdrive_neg,
   // Mode pins (asynchronous)
   input  wire [1:0]  format_select_pin,
   input  wire        output_enable,
   input  wire        hw_reset,
   // Parallel output pins, enables low while driving
   output reg  [13:0] sample_out,
   output reg  [13:0] sample_oe_n,
   output reg         over_range_flag,
   output reg         over_range_oe_n,
   output reg         data_ready_clock,
   output reg         data_ready_oe_n,
   // Interrupt
   output wire        irq
);

   localparam CW = 16;

   ////////////////////////////////////////////////////////////////////////////////
   // Functions

   function [13:0] fmt_code;
      input [13:0] ob;
      input        twos;
      begin
         fmt_code = twos ? {~ob[13], ob[12:0]} : ob;
      end
   endfunction

   function at_full_scale;
      input [13:0] ob;
      begin
         at_full_scale = (ob == `CODE_POS_FS) || (ob == `CODE_NEG_FS);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers

   reg        sclk_s1_reg;
   reg        sclk_s2_reg;
   reg        sclk_d_reg;
   reg [15:0] core_s1_reg;
   reg [15:0] core_s2_reg;
   reg [3:0]  pin_s1_reg;
   reg [3:0]  pin_s2_reg;

   always @(posedge clock) begin
      if (!nrst) begin
         sclk_s1_reg <= 1'b0;
         sclk_s2_reg <= 1'b0;
         sclk_d_reg  <= 1'b0;
         core_s1_reg <= 16'h0000;
         core_s2_reg <= 16'h0000;
         pin_s1_reg  <= 4'h0;
         pin_s2_reg  <= 4'h0;
      end else begin
         sclk_s1_reg <= sample_clk;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_d_reg  <= sclk_s2_reg;
         core_s1_reg <= {overdrive_neg, overdrive_pos, core_sample};
         core_s2_reg <= core_s1_reg;
         pin_s1_reg  <= {hw_reset, output_enable, format_select_pin};
         pin_s2_reg  <= pin_s1_reg;
      end
   end

   wire       sclk_rise = sclk_s2_reg & ~sclk_d_reg;
   wire       sclk_fall = ~sclk_s2_reg & sclk_d_reg;
   wire [1:0] fmt       = pin_s2_reg[1:0];
   wire       oe_pin    = pin_s2_reg[2];
   wire       hwrst_pin = pin_s2_reg[3];

   ////////////////////////////////////////////////////////////////////////////////
   // Hardware reset pulse qualification

   reg [CW-1:0] hwrst_cnt_reg;
   reg          hwrst_hit_reg;

   always @(posedge clock) begin
      if (!nrst) begin
         hwrst_cnt_reg <= {CW{1'b0}};
         hwrst_hit_reg <= 1'b0;
      end else if (!hwrst_pin) begin
         hwrst_cnt_reg <= {CW{1'b0}};
         hwrst_hit_reg <= 1'b0;
      end else if (hwrst_cnt_reg < HWRST_MIN_CYC[CW-1:0]) begin
         hwrst_cnt_reg <= hwrst_cnt_reg + 1'b1;
         hwrst_hit_reg <= (hwrst_cnt_reg == HWRST_MIN_CYC[CW-1:0] - 1'b1);
      end else begin
         hwrst_hit_reg <= 1'b0;
      end
   end

   // Held long enough and still high
   wire hwrst_active = hwrst_pin && (hwrst_cnt_reg >= HWRST_MIN_CYC[CW-1:0]);

   ////////////////////////////////////////////////////////////////////////////////
   // Slow or absent sample clock detection

   reg [CW-1:0] period_cnt_reg;
   reg          slow_reg;

   always @(posedge clock) begin
      if (!nrst) begin
         period_cnt_reg <= {CW{1'b0}};
         slow_reg       <= 1'b1;
      end else if (sclk_rise) begin
         period_cnt_reg <= {CW{1'b0}};
         slow_reg       <= (period_cnt_reg >= SLOW_LIMIT_CYC[CW-1:0]);
      end else if (period_cnt_reg < SLOW_LIMIT_CYC[CW-1:0]) begin
         period_cnt_reg <= period_cnt_reg + 1'b1;
      end else begin
         slow_reg <= 1'b1;
      end
   end

   wire slow_enter = slow_reg == 1'b0 && period_cnt_reg >= SLOW_LIMIT_CYC[CW-1:0]
                     && !sclk_rise;

   ////////////////////////////////////////////////////////////////////////////////
   // APB register file

   reg  [1:0]          ctrl_reg;
   reg  [`IRQ_W-1:0]   irq_status_reg;
   reg  [`IRQ_W-1:0]   irq_enable_reg;
   wire [`IRQ_W-1:0]   irq_event;
   reg  [`IRQ_W-1:0]   irq_clear;
   reg  [13:0]         last_sample_reg;
   reg                 addr_ok;

   wire apb_wr = psel & penable & pwrite;
   wire pd_bit = ctrl_reg[`CTRL_PWRDN_BIT];
   wire pd_active = pd_bit | slow_reg;

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;

   always @* begin
      addr_ok = 1'b1;
      prdata  = 32'h0000_0000;
      case (paddr)
         `OFS_CTRL: begin
            prdata[1:0] = ctrl_reg;
         end
         `OFS_STATUS: begin
            prdata[`ST_AUTO_PD_BIT]   = slow_reg;
            prdata[`ST_PD_ACTIVE_BIT] = pd_active;
            prdata[`ST_DLL_ON_BIT]    = ~ctrl_reg[`CTRL_DLL_OFF_BIT];
            prdata[`ST_FMT_LO_BIT+1:`ST_FMT_LO_BIT] = fmt;
            prdata[`ST_OE_PIN_BIT]    = oe_pin;
            prdata[`ST_HW_RESET_BIT]  = hwrst_active;
         end
         `OFS_IRQ_STATUS: begin
            prdata[`IRQ_W-1:0] = irq_status_reg;
         end
         `OFS_IRQ_ENABLE: begin
            prdata[`IRQ_W-1:0] = irq_enable_reg;
         end
         `OFS_IRQ_CLEAR: begin
            prdata = 32'h0000_0000;
         end
         `OFS_LAST_SAMPLE: begin
            prdata[13:0] = last_sample_reg;
         end
         default: begin
            addr_ok = 1'b0;
         end
      endcase
   end

   always @* begin
      irq_clear = {`IRQ_W{1'b0}};
      if (apb_wr && paddr == `OFS_IRQ_CLEAR) begin
         irq_clear = pwdata[`IRQ_W-1:0];
      end
   end

   always @(posedge clock) begin
      if (!nrst) begin
         ctrl_reg       <= `CTRL_RESET;
         irq_status_reg <= `IRQ_RESET;
         irq_enable_reg <= `IRQ_RESET;
      end else begin
         if (hwrst_active) begin
            ctrl_reg <= `CTRL_RESET;
         end else if (apb_wr && paddr == `OFS_CTRL) begin
            ctrl_reg <= pwdata[1:0];
         end
         if (apb_wr && paddr == `OFS_IRQ_ENABLE) begin
            irq_enable_reg <= pwdata[`IRQ_W-1:0];
         end
         // Set wins over a clear in the same cycle
         irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
      end
   end

   assign irq = |(irq_status_reg & irq_enable_reg);

   ////////////////////////////////////////////////////////////////////////////////
   // Conversion pipeline

   reg  [`PIPE_AW-1:0] wr_ptr_reg;
   reg  [CW-1:0]       fill_reg;
   reg                 load_reg;
   wire [13:0]         ram_q;
   wire                run = ~pd_active & ~hwrst_active;
   wire                capture = run & sclk_fall;
   wire                fetch = run & sclk_rise & (fill_reg > LATENCY[CW-1:0]);
   wire [`PIPE_AW-1:0] rd_ptr = wr_ptr_reg - 1'b1 - LATENCY[`PIPE_AW-1:0];
   wire                od_pos = core_s2_reg[14];
   wire                od_neg = core_s2_reg[15];
   reg  [13:0]         clamped;

   always @* begin
      clamped = core_s2_reg[13:0];
      if (od_pos) begin
         clamped = `CODE_POS_FS;
      end else if (od_neg) begin
         clamped = `CODE_NEG_FS;
      end
   end

   sample_ram #(
      .WIDTH (14),
      .AW    (`PIPE_AW)
   ) u_ram (
      .clock   (clock),
      .wr_en   (capture),
      .wr_addr (wr_ptr_reg),
      .wr_data (clamped),
      .rd_en   (fetch),
      .rd_addr (rd_ptr),
      .rd_data (ram_q)
   );

   always @(posedge clock) begin
      if (!nrst || !run) begin
         wr_ptr_reg <= {`PIPE_AW{1'b0}};
         fill_reg   <= {CW{1'b0}};
         load_reg   <= 1'b0;
      end else begin
         load_reg <= fetch;
         if (capture) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (fill_reg < LATENCY[CW-1:0] + 1'b1) begin
               fill_reg <= fill_reg + 1'b1;
            end
         end
      end
   end

   assign irq_event[`IRQ_SLOW_BIT]  = slow_enter;
   assign irq_event[`IRQ_RANGE_BIT] = load_reg & at_full_scale(ram_q);
   assign irq_event[`IRQ_HWRST_BIT] = hwrst_hit_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Output pins

   wire outputs_off = pd_active | ~oe_pin;

   always @(posedge clock) begin
      if (!nrst || hwrst_active) begin
         sample_out       <= 14'h0000;
         over_range_flag  <= 1'b0;
         last_sample_reg  <= 14'h0000;
         data_ready_clock <= 1'b0;
      end else begin
         if (load_reg) begin
            sample_out      <= fmt_code(ram_q, fmt[`FMT_TWOS_BIT]);
            over_range_flag <= at_full_scale(ram_q);
            last_sample_reg <= ram_q;
         end
         // Falling-edge mode: data moves on the rise, stable at the fall
         data_ready_clock <= fmt[`FMT_FALL_BIT] ? sclk_d_reg : ~sclk_d_reg;
      end
   end

   always @(posedge clock) begin
      if (!nrst) begin
         sample_oe_n     <= 14'h3fff;
         over_range_oe_n <= 1'b1;
         data_ready_oe_n <= 1'b1;
      end else begin
         sample_oe_n     <= {14{outputs_off}};
         over_range_oe_n <= outputs_off;
         data_ready_oe_n <= outputs_off;
      end
   end

endmodule

`default_nettype wire

// [rtl/adc_out_regs.vh]
// Register offsets, field positions, reset values and timing counts
`ifndef ADC_OUT_REGS_VH
`define ADC_OUT_REGS_VH

// Clock
`define CLK_PERIOD_NS      100

// APB byte offsets
`define OFS_CTRL           8'h00
`define OFS_STATUS         8'h04
`define OFS_IRQ_STATUS     8'h08
`define OFS_IRQ_ENABLE     8'h0c
`define OFS_IRQ_CLEAR      8'h10
`define OFS_LAST_SAMPLE    8'h14

// Control register fields
`define CTRL_PWRDN_BIT     0
`define CTRL_DLL_OFF_BIT   1
`define CTRL_RESET         2'h0

// Status register fields
`define ST_AUTO_PD_BIT     0
`define ST_PD_ACTIVE_BIT   1
`define ST_DLL_ON_BIT      2
`define ST_FMT_LO_BIT      4
`define ST_OE_PIN_BIT      6
`define ST_HW_RESET_BIT    7

// Interrupt fields
`define IRQ_W              3
`define IRQ_SLOW_BIT       0
`define IRQ_RANGE_BIT      1
`define IRQ_HWRST_BIT      2
`define IRQ_RESET          3'h0

// Format select: bit 1 chooses two's complement, bit 0 latching on falling edge
`define FMT_TWOS_BIT       1
`define FMT_FALL_BIT       0

// Sample codes
`define SAMPLE_W           14
`define CODE_POS_FS        14'h3fff
`define CODE_NEG_FS        14'h0000

// Pipeline latency in whole sample-clock falls (half cycle added on rise)
`define PIPE_LATENCY       17
`define PIPE_AW            5

// Slow-clock limit: a sample period longer than this means below 2 Msps
`define SLOW_PERIOD_NS     500
`define SLOW_LIMIT_CYC     (`SLOW_PERIOD_NS / `CLK_PERIOD_NS)

// Hardware reset pulse minimum width
`define HWRST_MIN_NS       2000
`define HWRST_MIN_CYC      ((`HWRST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/sample_ram.v]
// Small dual-port memory holding samples in flight through the pipeline
`timescale 1ns/1ps
`default_nettype none

module sample_ram #(
   parameter WIDTH = 14,
   parameter AW    = 5
) (
   // Clock
   input  wire             clock,
   // Write port
   input  wire             wr_en,
   input  wire [AW-1:0]    wr_addr,
   input  wire [WIDTH-1:0] wr_data,
   // Read port, data registered
   input  wire             rd_en,
   input  wire [AW-1:0]    rd_addr,
   output reg  [WIDTH-1:0] rd_data
);

   reg [WIDTH-1:0] mem [0:(1<<AW)-1];

   always @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

`default_nettype wire

// [dv/adc_out_props.sv]
// Concurrent checks on the ports of the output and power control block
`timescale 1ns/1ps
`default_nettype none
`include "adc_out_regs.vh"
module adc_out_props #(
   parameter SLOW_LIMIT_CYC = 5,
   parameter HWRST_MIN_CYC  = 20,
   parameter LATENCY        = 17
) (
   // Clock, reset and bus
   input wire logic        clock,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   // Pins
   input wire logic        sample_clk,
   input wire logic        output_enable,
   input wire logic        hw_reset,
   input wire logic [13:0] sample_out,
   input wire logic [13:0] sample_oe_n,
   input wire logic        over_range_flag,
   input wire logic        over_range_oe_n,
   input wire logic        data_ready_clock,
   input wire logic        data_ready_oe_n,
   input wire logic        irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   logic [7:0] hr_cnt;
   logic [7:0] sc_cnt = 8'h00;
   logic       sc_last;
   wire        hiz = &sample_oe_n && over_range_oe_n && data_ready_oe_n;
   ////////////////////////////////////////////////////////////////////////////////
   // Run lengths of a held reset pin and of a still sample clock
   always @(posedge clock) begin
      sc_last <= sample_clk;
      if (!hw_reset) hr_cnt <= 8'h00;
      else if (hr_cnt != 8'hff) hr_cnt <= hr_cnt + 8'h01;
      if (sample_clk != sc_last) sc_cnt <= 8'h00;
      else if (sc_cnt != 8'hff) sc_cnt <= sc_cnt + 8'h01;
   end
   ////////////////////////////////////////////////////////////////////////////////
   oe_pin_a: assert property ($fell(output_enable) |-> ##[1:4] hiz)
      else $error("outputs driven after output enable fell");
   oe_same_a: assert property (
      sample_oe_n == {14{over_range_oe_n}} && data_ready_oe_n == over_range_oe_n)
      else $error("output enables disagree");
   pd_bit_a: assert property (
      psel && penable && pwrite && paddr == `OFS_CTRL && pwdata[0] && !hw_reset
      |-> ##[1:3] hiz)
      else $error("power-down bit left outputs driven");
   slow_clock_a: assert property (sc_cnt > 2 * SLOW_LIMIT_CYC + 6 && !hw_reset |-> hiz)
      else $error("stopped sample clock left outputs driven");
   range_flag_a: assert property (
      over_range_flag |-> sample_out inside {14'h3fff, 14'h0000, 14'h1fff, 14'h2000})
      else $error("over-range flag on a mid-scale word");
   pin_reset_a: assert property (
      hr_cnt > HWRST_MIN_CYC + 4 |-> sample_out == 14'h0000 && !over_range_flag
      && !data_ready_clock)
      else $error("reset pin did not clear outputs");
   reset_state_a: assert property ($rose(nrst) |-> sample_out == 14'h0000 && hiz && !irq)
      else $error("outputs not at reset state");
   bus_error_a: assert property (psel && penable && paddr[1:0] == 2'b00
      |-> pslverr == (paddr > `OFS_LAST_SAMPLE))
      else $error("bus error response wrong");
endmodule
bind adc_output_and_power_control adc_out_props #(.SLOW_LIMIT_CYC(SLOW_LIMIT_CYC),
   .HWRST_MIN_CYC(HWRST_MIN_CYC), .LATENCY(LATENCY)) props_i (
   .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .sample_clk(sample_clk),
   .output_enable(output_enable), .hw_reset(hw_reset), .sample_out(sample_out),
   .sample_oe_n(sample_oe_n), .over_range_flag(over_range_flag),
   .over_range_oe_n(over_range_oe_n), .data_ready_clock(data_ready_clock),
   .data_ready_oe_n(data_ready_oe_n), .irq(irq));
`default_nettype wire

// [dv/capture_model.sv]
// Capture logic latching the parallel word on the data-ready clock
`timescale 1ns/1ps
`default_nettype none
module capture_model (
   // Pins from the converter
   input wire logic [13:0] sample_out,
   input wire logic [13:0] sample_oe_n,
   input wire logic        data_ready_clock,
   input wire logic        data_ready_oe_n,
   // High to latch on the falling edge
   input wire logic        falling,
   // Captured word
   output logic [13:0]     word
);
   logic [13:0] held = 14'h0000;
   logic        ck_held = 1'b0;
   // Released lines show the inverse of their last driven level
   wire  [13:0] pin = (sample_out & ~sample_oe_n) | (~held & sample_oe_n);
   wire         ck = data_ready_oe_n ? ~ck_held : data_ready_clock;
   always @(sample_out, sample_oe_n) held = (sample_out & ~sample_oe_n) | (held & sample_oe_n);
   always @(data_ready_clock, data_ready_oe_n) if (!data_ready_oe_n) ck_held = data_ready_clock;
   always @(ck) begin
      if (data_ready_oe_n === 1'b0 && ck === ~falling) word <= pin;
   end
endmodule
`default_nettype wire

// [dv/test_adc_output_and_power_control.sv]
// Self-checking bench of the output and power control block
`timescale 1ns/1ps
`default_nettype none
`include "adc_out_regs.vh"
module test_adc_output_and_power_control;
   logic        clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd;
   logic        err, sample_clk = 1'b0, sc_run = 1'b1, od_pos = 1'b0, od_neg = 1'b0;
   logic [13:0] core_sample = 14'h0000, core_nxt = 14'h0000;
   logic [1:0]  fmt = 2'b00;
   logic        oe = 1'b1, hw_reset = 1'b0;
   wire         pready, pslverr, irq, range_flag, range_oe_n, drdy, drdy_oe_n;
   wire  [31:0] prdata;
   wire  [13:0] sample_out, sample_oe_n, word;
   int          failures = 0, n_compared = 0, n_wait = 0;
   always #50 clock = ~clock;
   always #400 if (sc_run) sample_clk = ~sample_clk;
   always @(posedge sample_clk) core_sample <= core_nxt;
   adc_output_and_power_control #(.SLOW_LIMIT_CYC(12), .HWRST_MIN_CYC(3)) dut (
      .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .sample_clk(sample_clk), .core_sample(core_sample), .overdrive_pos(od_pos),
      .overdrive_neg(od_neg), .format_select_pin(fmt), .output_enable(oe),
      .hw_reset(hw_reset), .sample_out(sample_out), .sample_oe_n(sample_oe_n),
      .over_range_flag(range_flag), .over_range_oe_n(range_oe_n), .data_ready_clock(drdy),
      .data_ready_oe_n(drdy_oe_n), .irq(irq));
   capture_model cap (.sample_out(sample_out), .sample_oe_n(sample_oe_n),
      .data_ready_clock(drdy), .data_ready_oe_n(drdy_oe_n), .falling(fmt[0]), .word(word));
   ////////////////////////////////////////////////////////////////////////////////
   task end_of_test;
      if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wclk(input int n);
      repeat (n) @(posedge clock);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         failures++;
         end_of_test;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd & m, exp);
   endtask
   // Settled word, flag and enable, and what the capture side latched
   task pins(input logic [13:0] w, input logic f);
      chk({16'h0, sample_oe_n[0], range_flag, sample_out}, {16'h0, 1'b0, f, w});
      chk({18'h0, word}, {18'h0, w});
   endtask
   task hz(input logic e);
      chk({31'h0, range_oe_n & drdy_oe_n & sample_oe_n[13]}, {31'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      wclk(10);
      nrst <= 1'b1;
      wclk(170);
      rd_chk(`OFS_CTRL, 32'h3, 32'h0);
      rd_chk(`OFS_STATUS, 32'h7, 32'h4);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, err}, 32'h1);
      core_nxt <= 14'h1234;
      wclk(170);
      pins(14'h1234, 1'b0);
      core_nxt <= 14'h0abc;
      // Bounded wait for the next sample clock rise
      n_wait = 0;
      while (sample_clk !== 1'b0 && n_wait < 20) begin
         wclk(1);
         n_wait++;
      end
      while (sample_clk !== 1'b1 && n_wait < 40) begin
         wclk(1);
         n_wait++;
      end
      if (sample_clk !== 1'b1) begin
         failures++;
         end_of_test;
      end
      wclk(143);
      chk({18'h0, sample_out}, 32'h1234);
      wclk(10);
      chk({18'h0, sample_out}, 32'h0abc);
      for (int f = 0; f < 4; f++) begin
         fmt <= f[1:0];
         wclk(170);
         pins(f[1] ? 14'h2abc : 14'h0abc, 1'b0);
         rd_chk(`OFS_STATUS, 32'h30, f << 4);
      end
      apb(1'b1, `OFS_IRQ_ENABLE, 32'h2);
      for (int i = 0; i < 4; i++) begin
         fmt <= {i[0], 1'b0};
         od_pos <= !i[1];
         od_neg <= i[1];
         wclk(170);
         pins(i[1] ? {i[0], 13'h0} : {!i[0], 13'h1fff}, 1'b1);
         chk({31'h0, irq}, 32'h1);
      end
      od_neg <= 1'b0;
      fmt <= 2'b00;
      wclk(170);
      apb(1'b1, `OFS_IRQ_CLEAR, 32'h2);
      rd_chk(`OFS_IRQ_STATUS, 32'h2, 32'h0);
      chk({31'h0, irq}, 32'h0);
      rd_chk(`OFS_LAST_SAMPLE, 32'h3fff, 32'h0abc);
      apb(1'b1, `OFS_IRQ_ENABLE, 32'h0);
      od_pos <= 1'b1;
      wclk(170);
      rd_chk(`OFS_IRQ_STATUS, 32'h2, 32'h2);
      chk({31'h0, irq}, 32'h0);
      od_pos <= 1'b0;
      oe <= 1'b0;
      wclk(20);
      hz(1'b1);
      oe <= 1'b1;
      apb(1'b1, `OFS_CTRL, 32'h1);
      wclk(5);
      hz(1'b1);
      rd_chk(`OFS_STATUS, 32'h6, 32'h6);
      apb(1'b1, `OFS_CTRL, 32'h2);
      rd_chk(`OFS_STATUS, 32'h6, 32'h0);
      apb(1'b1, `OFS_IRQ_CLEAR, 32'h7);
      sc_run <= 1'b0;
      wclk(60);
      hz(1'b1);
      rd_chk(`OFS_STATUS, 32'h1, 32'h1);
      rd_chk(`OFS_IRQ_STATUS, 32'h1, 32'h1);
      sc_run <= 1'b1;
      wclk(170);
      pins(14'h0abc, 1'b0);
      hw_reset <= 1'b1;
      wclk(12);
      chk({18'h0, sample_out}, 32'h0);
      rd_chk(`OFS_CTRL, 32'h3, 32'h0);
      rd_chk(`OFS_STATUS, 32'h80, 32'h80);
      hw_reset <= 1'b0;
      wclk(5);
      rd_chk(`OFS_IRQ_STATUS, 32'h4, 32'h4);
      end_of_test;
   end
endmodule
`default_nettype wire
